// *** src/coprocessor_handshake_port.sv ***
// Core-side coprocessor handshake port: follower strobes, commit, data paths
`timescale 1ns/1ps
`default_nettype none

module coprocessor_handshake_port #(
  parameter int DW = cp_port_pkg::DATA_W  // Data path width
) (
  input  wire logic                    mclk,                   // Bus clock
  input  wire logic                    srst,                   // Sync reset
  // Core pipeline side
  input  wire logic                    bus_cycle_enable,       // Core bus cycle advances
  input  wire cp_port_pkg::follow_type follow_in,              // Core follower strobes
  input  wire logic                    cp_exec_valid,          // Cp instruction in execute
  input  wire logic                    cp_cond_pass,           // Condition test passed
  input  wire cp_port_pkg::kind_type   cp_kind,                // Instruction kind
  input  wire logic                    irq_pending,            // Enabled fast/normal irq
  input  wire logic [DW-1:0]           core_wr_data,           // Data for the coprocessor
  output logic                         core_stall,             // Core held in busy-wait
  output logic                         cp_done,                // Instruction committed
  output logic                         cp_abandoned,           // Abandoned by interrupt
  output logic                         undef_trap,             // Take undefined trap
  output logic                         store_nonseq,           // Issue as nonsequential
  output logic [DW-1:0]                core_rd_data,           // Data from coprocessor
  output logic                         core_rd_valid,          // Read data captured
  // Coprocessor pins
  output logic                         coproc_clock_enable,    // Coprocessor clock enable
  output cp_port_pkg::follow_type      follow_out,             // Follower strobes out
  output logic                         coproc_commit_n,        // Commit, active low
  output logic [DW-1:0]                core_to_coproc_data,    // Core to coprocessor data
  input  wire logic                    coproc_absent_in,       // ANDed absent line
  input  wire logic                    coproc_busy_in,         // ANDed busy line
  input  wire logic [DW-1:0]           coproc_to_core_data,    // Coprocessor to core data
  input  wire logic                    coproc_data_bus_enable  // Coprocessor drives data
);

  // ****************************************
  // Pin synchronisers
  // ****************************************
  cp_port_pkg::resp_type resp_s1_r;  // First stage, read by second only
  cp_port_pkg::resp_type resp_s2_r;  // Synchronised response
  logic [DW-1:0]         din_s1_r;   // First stage data
  logic [DW-1:0]         din_s2_r;   // Synchronised data
  logic                  dbe_s1_r;   // First stage enable
  logic                  dbe_s2_r;   // Synchronised enable

  // Two flops on every coprocessor input
  always_ff @(posedge mclk) begin
    if (srst) begin
      resp_s1_r <= '{absent: 1'h1, busy: 1'h1};
      resp_s2_r <= '{absent: 1'h1, busy: 1'h1};
      din_s1_r  <= '0;
      din_s2_r  <= '0;
      dbe_s1_r  <= 1'h0;
      dbe_s2_r  <= 1'h0;
    end else begin
      resp_s1_r <= '{absent: coproc_absent_in, busy: coproc_busy_in};
      resp_s2_r <= resp_s1_r;
      din_s1_r  <= coproc_to_core_data;
      din_s2_r  <= din_s1_r;
      dbe_s1_r  <= coproc_data_bus_enable;
      dbe_s2_r  <= dbe_s1_r;
    end
  end

  // ****************************************
  // Handshake state
  // ****************************************
  cp_port_pkg::hs_state_type state_r, state_nxt;      // Handshake state
  cp_port_pkg::kind_type     kind_r, kind_nxt;        // Latched kind
  logic                      commit_n_r, commit_n_nxt;  // Commit pin
  logic                      stall_r, stall_nxt;      // Core stall
  logic                      done_r, done_nxt;        // Commit pulse
  logic                      aband_r, aband_nxt;      // Abandon pulse
  logic                      undef_r, undef_nxt;      // Trap pulse
  logic                      nonseq_r, nonseq_nxt;    // Store nonsequential
  logic [DW-1:0]             rd_r, rd_nxt;            // Read data
  logic                      rdv_r, rdv_nxt;          // Read valid pulse
  logic                      accept_now;              // Absent low, busy low
  logic                      accept_wait;             // Absent low, busy high

  assign accept_now  = !resp_s2_r.absent && !resp_s2_r.busy;
  assign accept_wait = !resp_s2_r.absent && resp_s2_r.busy;

  // Next handshake values
  always_comb begin
    state_nxt    = state_r;
    kind_nxt     = kind_r;
    commit_n_nxt = cp_port_pkg::RST_COMMIT_N;
    stall_nxt    = 1'h0;
    done_nxt     = 1'h0;
    aband_nxt    = 1'h0;
    undef_nxt    = 1'h0;
    nonseq_nxt   = nonseq_r;
    rd_nxt       = rd_r;
    rdv_nxt      = 1'h0;
    case (state_r)
      // Wait for an executed coprocessor instruction
      cp_port_pkg::ST_IDLE: begin
        nonseq_nxt = 1'h0;
        if (cp_exec_valid && cp_cond_pass) begin
          kind_nxt = cp_kind;
          if (resp_s2_r.absent) begin
            undef_nxt = 1'h1;
          end else if (accept_now) begin
            commit_n_nxt = 1'h0;
            state_nxt    = cp_port_pkg::ST_COMMIT;
          end else if (accept_wait) begin
            stall_nxt = 1'h1;
            state_nxt = cp_port_pkg::ST_WAIT;
          end
        end
      end
      // Busy-wait until ready, interrupted or refused
      cp_port_pkg::ST_WAIT: begin
        if (irq_pending) begin
          aband_nxt = 1'h1;
          state_nxt = cp_port_pkg::ST_IDLE;
        end else if (accept_now) begin
          commit_n_nxt = 1'h0;
          state_nxt    = cp_port_pkg::ST_COMMIT;
        // Withdrawn acceptance traps
        end else if (resp_s2_r.absent) begin
          undef_nxt = 1'h1;
          state_nxt = cp_port_pkg::ST_IDLE;
        end else begin
          stall_nxt = 1'h1;
        end
      end
      // Commit strobe low for one cycle
      cp_port_pkg::ST_COMMIT: begin
        done_nxt   = 1'h1;
        nonseq_nxt = kind_r.mem_store;
        if (kind_r.from_reg && dbe_s2_r) begin
          rd_nxt  = din_s2_r;
          rdv_nxt = 1'h1;
        end
        state_nxt = cp_port_pkg::ST_IDLE;
      end
      default: begin
        state_nxt = cp_port_pkg::ST_IDLE;
      end
    endcase
  end

  // Register handshake values
  always_ff @(posedge mclk) begin
    if (srst) begin
      state_r    <= cp_port_pkg::ST_IDLE;
      kind_r     <= '0;
      commit_n_r <= cp_port_pkg::RST_COMMIT_N;
      stall_r    <= 1'h0;
      done_r     <= 1'h0;
      aband_r    <= 1'h0;
      undef_r    <= 1'h0;
      nonseq_r   <= 1'h0;
      rd_r       <= '0;
      rdv_r      <= 1'h0;
    end else begin
      state_r    <= state_nxt;
      kind_r     <= kind_nxt;
      commit_n_r <= commit_n_nxt;
      stall_r    <= stall_nxt;
      done_r     <= done_nxt;
      aband_r    <= aband_nxt;
      undef_r    <= undef_nxt;
      nonseq_r   <= nonseq_nxt;
      rd_r       <= rd_nxt;
      rdv_r      <= rdv_nxt;
    end
  end

  // ****************************************
  // Follower pins and write data
  // ****************************************
  cp_port_pkg::follow_type follow_r, follow_nxt;  // Registered strobes
  logic                    clken_r, clken_nxt;    // Clock enable pin
  logic [DW-1:0]           wr_r, wr_nxt;          // Write data pin

  // Next follower and write values
  always_comb begin
    follow_nxt = follow_in;
    clken_nxt  = bus_cycle_enable;
    wr_nxt     = core_wr_data;
  end

  // Register follower and write values
  always_ff @(posedge mclk) begin
    if (srst) begin
      follow_r <= '{opcode_fetch_n: cp_port_pkg::RST_FOLLOW_N,
                    memory_request_n: cp_port_pkg::RST_FOLLOW_N,
                    privilege_indicator_n: 1'h0,
                    compressed_state_flag: 1'h0};
      clken_r  <= 1'h0;
      wr_r     <= '0;
    end else begin
      follow_r <= follow_nxt;
      clken_r  <= clken_nxt;
      wr_r     <= wr_nxt;
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  assign core_stall          = stall_r;
  assign cp_done             = done_r;
  assign cp_abandoned        = aband_r;
  assign undef_trap          = undef_r;
  assign store_nonseq        = nonseq_r;
  assign core_rd_data        = rd_r;
  assign core_rd_valid       = rdv_r;
  assign coproc_clock_enable = clken_r;
  assign follow_out          = follow_r;
  assign coproc_commit_n     = commit_n_r;
  assign core_to_coproc_data = wr_r;

endmodule : coprocessor_handshake_port

`default_nettype wire

// *** src/cp_port_pkg.sv ***
// Shared constants and carrier types for the coprocessor handshake port
package cp_port_pkg;

  // ****************************************
  // Widths and counts
  // ****************************************
  localparam int DATA_W          = 32;  // Coprocessor data paths
  localparam int MAX_BURST_WORDS = 16;  // Conventional coprocessor transfer limit

  // ****************************************
  // Reset values of pins
  // ****************************************
  localparam logic RST_COMMIT_N = 1'h1;  // Commit idles high (not committed)
  localparam logic RST_FOLLOW_N = 1'h1;  // Opcode fetch and memory request strobes idle high

  // ****************************************
  // Handshake states
  // ****************************************
  typedef enum logic [1:0] {
    ST_IDLE   = 2'b00,  // No coprocessor instruction in execute
    ST_WAIT   = 2'b01,  // Busy-wait on the coprocessor
    ST_COMMIT = 2'b10   // Commit strobe driven low
  } hs_state_type;

  // ****************************************
  // Carriers
  // ****************************************
  // Pipeline-following strobes as seen on the pins
  typedef struct packed {
    logic opcode_fetch_n;         // Low on an opcode fetch
    logic memory_request_n;       // Low on a memory request
    logic privilege_indicator_n;  // Low for user mode
    logic compressed_state_flag;  // High in compressed state
  } follow_type;

  // Coprocessor response pair
  typedef struct packed {
    logic absent;  // Coprocessor absent
    logic busy;    // Coprocessor busy
  } resp_type;

  // Kind of the coprocessor instruction in execute
  typedef struct packed {
    logic mem_store;  // Coprocessor memory store
    logic mem_load;   // Coprocessor memory load
    logic from_reg;   // Move from coprocessor register
    logic to_reg;     // Move to coprocessor register
  } kind_type;

endpackage : cp_port_pkg

// *** verif/cp_port_checker.sv ***
// Concurrent checks on the coprocessor handshake port pins
`timescale 1ns/1ps
`default_nettype none
module cp_port_checker #(
  parameter int DW = 32  // Data path width
) (
  input wire logic                    mclk,
  input wire logic                    srst,
  input wire logic                    cp_exec_valid,
  input wire logic                    cp_cond_pass,
  input wire logic                    irq_pending,
  input wire cp_port_pkg::follow_type follow_in,
  input wire logic [DW-1:0]           core_wr_data,
  input wire logic                    core_stall,
  input wire logic                    cp_done,
  input wire logic                    cp_abandoned,
  input wire logic                    undef_trap,
  input wire logic                    store_nonseq,
  input wire cp_port_pkg::follow_type follow_out,
  input wire logic                    coproc_commit_n,
  input wire logic [DW-1:0]           core_to_coproc_data,
  input wire logic                    coproc_absent_in,
  input wire logic                    bus_cycle_enable,
  input wire logic                    coproc_clock_enable
);
  // ****************************************
  // Handshake properties
  // ****************************************
  default clocking @(posedge mclk); endclocking
  default disable iff (srst);
  // One-cycle commit followed by completion
  sequence s_commit; !coproc_commit_n ##1 (coproc_commit_n && cp_done); endsequence
  // Abandon pulse with the stall released and no commit
  sequence s_drop; cp_abandoned && !core_stall && coproc_commit_n; endsequence
  AST_COMMIT_PULSE: assert property (!coproc_commit_n |-> s_commit)
    else $error("commit pulse malformed");
  AST_COMMIT_CAUSE: assert property ($fell(coproc_commit_n) |->
    $past(cp_exec_valid && cp_cond_pass)) else $error("commit without passed request");
  AST_STALL_NO_COMMIT: assert property (core_stall |-> coproc_commit_n)
    else $error("commit during busy-wait");
  AST_ABANDON: assert property (core_stall && irq_pending |=> s_drop)
    else $error("interrupt did not abandon");
  AST_ABANDON_CAUSE: assert property (cp_abandoned |-> $past(irq_pending && core_stall))
    else $error("abandon without interrupt");
  AST_UNDEF: assert property (undef_trap |-> coproc_commit_n && ($past(coproc_absent_in, 2) ||
    $past(coproc_absent_in, 3) || $past(coproc_absent_in, 4)) ##1 !undef_trap)
    else $error("trap without absent coprocessor");
  AST_FOLLOW: assert property (!$past(srst) |-> follow_out == $past(follow_in))
    else $error("follower strobes not passed on");
  AST_WDATA: assert property (!$past(srst) |-> core_to_coproc_data == $past(core_wr_data))
    else $error("write data not passed on");
  AST_NONSEQ: assert property ($rose(store_nonseq) |-> cp_done)
    else $error("nonsequential flag without completion");
  AST_CLKEN: assert property (!$past(srst) |->
    coproc_clock_enable == $past(bus_cycle_enable)) else $error("clock enable not passed on");
endmodule : cp_port_checker
bind coprocessor_handshake_port cp_port_checker #(.DW(DW)) chk_i (.mclk, .srst, .cp_exec_valid,
  .cp_cond_pass, .irq_pending, .follow_in, .core_wr_data, .core_stall, .cp_done, .cp_abandoned,
  .undef_trap, .store_nonseq, .follow_out, .coproc_commit_n, .core_to_coproc_data,
  .coproc_absent_in, .bus_cycle_enable, .coproc_clock_enable);
`default_nettype wire

// *** verif/cp_far_model.sv ***
// Behavioural external coprocessor facing the handshake port
`timescale 1ns/1ps
`default_nettype none
module cp_far_model (
  input  wire logic                    mclk,
  input  wire logic                    srst,
  input  wire logic                    coproc_clock_enable,
  input  wire cp_port_pkg::follow_type follow_out,
  input  wire logic                    accept,       // Accepts decoded instruction
  input  wire logic                    hold_busy,    // Busy-wait request
  input  wire logic                    drv,          // Drives read data
  input  wire logic [31:0]             rd_word,      // Read-back word
  output logic                         coproc_absent_in,
  output logic                         coproc_busy_in,
  output logic [31:0]                  coproc_to_core_data,
  output logic                         coproc_data_bus_enable
);
  logic        fetch_r, fetch_nxt;  // Previous cycle was a full-width fetch
  logic        live_r, live_nxt;    // Decode stage holds a valid opcode
  logic        exe_r, exe_nxt;      // Execute stage holds a valid opcode
  logic [31:0] last_r, last_nxt;    // Last word driven
  // Follower next state
  always_comb begin
    fetch_nxt = fetch_r;
    live_nxt  = live_r;
    exe_nxt   = exe_r;
    last_nxt  = last_r;
    if (coproc_clock_enable) begin
      fetch_nxt = !follow_out.opcode_fetch_n && !follow_out.memory_request_n
                  && !follow_out.compressed_state_flag;
      if (fetch_r) begin
        live_nxt = 1'b1;
      end
      if (fetch_nxt) begin
        exe_nxt = live_r;
      end
      if (drv && !hold_busy) begin
        last_nxt = rd_word;
      end
    end
  end
  // Register follower state
  always_ff @(posedge mclk) begin
    if (srst) begin
      fetch_r <= 1'b0;
      live_r  <= 1'b0;
      exe_r   <= 1'b0;
      last_r  <= '0;
    end else begin
      fetch_r <= fetch_nxt;
      live_r  <= live_nxt;
      exe_r   <= exe_nxt;
      last_r  <= last_nxt;
    end
  end
  // one unit on its own number, AND of one
  assign coproc_absent_in = !accept;
  assign coproc_busy_in = !accept || hold_busy;
  assign coproc_data_bus_enable = drv;
  assign coproc_to_core_data = drv ? rd_word : ~last_r;
endmodule : cp_far_model
`default_nettype wire

// *** verif/coprocessor_handshake_port_tb_top.sv ***
// Self-checking bench for the coprocessor handshake port
`timescale 1ns/1ps
`default_nettype none
module coprocessor_handshake_port_tb_top;
  logic mclk, srst, bus_cycle_enable, cp_exec_valid, cp_cond_pass, irq_pending;
  logic core_stall, cp_done, cp_abandoned, undef_trap, store_nonseq, core_rd_valid;
  logic coproc_clock_enable, coproc_commit_n, coproc_absent_in, coproc_busy_in;
  logic coproc_data_bus_enable, accept, hold_busy, drv;
  logic [31:0] core_wr_data, core_rd_data, core_to_coproc_data, coproc_to_core_data, rd_word;
  cp_port_pkg::follow_type follow_in, follow_out;
  cp_port_pkg::kind_type   cp_kind;
  logic [36:0] notes[$];  // Expected events, oldest first
  logic [36:0] got;       // Observed event
  int          err_total, n_tests;
  coprocessor_handshake_port uut (.mclk, .srst, .bus_cycle_enable, .follow_in, .cp_exec_valid,
    .cp_cond_pass, .cp_kind, .irq_pending, .core_wr_data, .core_stall, .cp_done, .cp_abandoned,
    .undef_trap, .store_nonseq, .core_rd_data, .core_rd_valid, .coproc_clock_enable,
    .follow_out, .coproc_commit_n, .core_to_coproc_data, .coproc_absent_in, .coproc_busy_in,
    .coproc_to_core_data, .coproc_data_bus_enable);
  cp_far_model far_i (.mclk, .srst, .coproc_clock_enable, .follow_out, .accept, .hold_busy,
    .drv, .rd_word, .coproc_absent_in, .coproc_busy_in, .coproc_to_core_data,
    .coproc_data_bus_enable);
  // ****************************************
  // Clock, checks, closing
  // ****************************************
  initial begin
    mclk = 1'b0;
    forever #25 mclk = ~mclk;
  end
  task automatic chk(input logic [36:0] seen, input logic [36:0] want);
    n_tests++;
    if (seen !== want) begin
      err_total++;
      $display("BAD %0t event %h expected %h", $time, seen, want);
    end
  endtask : chk
  task automatic close_out();
    if (err_total == 0 && n_tests > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : close_out
  // Random traffic on pass-through inputs
  always @(negedge mclk) begin
    follow_in <= 4'($urandom);
    bus_cycle_enable <= 1'($urandom);
    core_wr_data <= $urandom;
  end
  // Monitor takes the oldest note per observed event
  always @(negedge mclk) begin
    if (!srst && (cp_done || undef_trap || cp_abandoned)) begin
      got = {cp_abandoned, undef_trap, cp_done, store_nonseq, core_rd_valid,
             core_rd_valid ? core_rd_data : 32'h0};
      if (notes.size() == 0) chk(got, 37'h0);
      else chk(got, notes.pop_front());
    end
  end
  // One instruction: w busy cycles, fin 0 ready, 1 interrupt, 2 refuse
  task automatic op(input logic [3:0] k, input logic a, input int w, input int fin,
                    input logic d, input logic c);
    logic rv;
    rv = k[1] & d;
    accept = a;
    hold_busy = (w > 0);
    drv = d;
    rd_word = $urandom;
    cp_kind = k;
    repeat (3) @(negedge mclk);
    cp_exec_valid = 1'b1;
    cp_cond_pass = c;
    if (c && (!a || (w > 0 && fin == 2))) notes.push_back({2'b01, 35'h0});
    else if (c && w > 0 && fin == 1) notes.push_back({1'b1, 36'h0});
    else if (c) notes.push_back({3'b001, k[3], rv, rv ? rd_word : 32'h0});
    @(negedge mclk);
    if (w > 0) begin
      repeat (w) @(negedge mclk);
      if (fin == 1) irq_pending = 1'b1;
      else if (fin == 2) accept = 1'b0;
      else hold_busy = 1'b0;
      @(negedge mclk);
      irq_pending = 1'b0;
      if (fin == 1) accept = 1'b0;
      for (int n = 0; n < 20 && core_stall; n++) @(negedge mclk);
    end
    cp_exec_valid = 1'b0;
    repeat (4) @(negedge mclk);
  endtask : op
  // Main sequence
  initial begin
    logic [3:0] k;  // Random instruction kind
    void'($urandom(32'h04C5));
    {srst, cp_exec_valid, cp_cond_pass, irq_pending} = 4'h8;
    {cp_kind, rd_word, drv, hold_busy} = '0;
    accept = 1'b1;
    err_total = 0;
    n_tests = 0;
    repeat (4) @(negedge mclk);
    srst = 1'b0;
    repeat (3) @(negedge mclk);
    for (int i = 0; i < 4; i++) op(4'h1 << i, 1'b1, 0, 0, 1'b1, 1'b1);
    op(4'h2, 1'b1, 0, 0, 1'b0, 1'b1);  // Read without bus enable
    op(4'h1, 1'b0, 0, 0, 1'b1, 1'b1);  // No coprocessor accepts
    op(4'h8, 1'b1, 3, 0, 1'b1, 1'b1);  // Busy-wait then ready
    op(4'h4, 1'b1, 2, 1, 1'b1, 1'b1);  // Busy-wait abandoned
    op(4'h2, 1'b1, 4, 2, 1'b1, 1'b1);  // Busy-wait then refused
    op(4'h1, 1'b1, 0, 0, 1'b1, 1'b0);  // Condition fails
    for (int i = 0; i < 8; i++) begin
      k = 4'(4'h1 << $urandom_range(3));
      op(k, 1'b1, $urandom_range(3), (k[3] | k[2]) ? $urandom_range(1) : $urandom_range(2),
         1'b1, 1'b1);
    end
    chk(37'(notes.size()), 37'h0);
    close_out();
  end
  // Watchdog
  initial begin
    #(50 * 6000);
    err_total++;
    close_out();
  end
endmodule : coprocessor_handshake_port_tb_top
`default_nettype wire
